// ---- design/fdc_decoder.sv ----
// opcode capture on the serial clock and command decode on the system clock
// assumes spi mode 0/3 sampling on the rising serial clock edge and a frame framed by CS_N
//
// How it works
// - 9F and AF identify, no address, quad ok
// - 5A reads parameter table, 3 address bytes, 50MHz
// - 05 reads status one, no address, quad ok
// - 07 reads status two, not in quad
// - 35 reads config one, not in quad
// - 01 writes status and config, quad ok
// - 30 clears fail flags, quad ok
// - config-three option turns 30 into resume
// - 82 always clears fail flags, quad ok
// - B7 enters wide address, not in quad
// - 41 reads learning pattern, not in quad
// - 43 programs nonvolatile learning register, not quad
// - 4A writes volatile learning register, not quad
// - wide-address bit makes legacy commands take four bytes
`default_nettype none
module fdc_decoder
  import fdc_pkg::*;
(
  input  wire logic       REF_CLK,
  input  wire logic       RSTN,
  input  wire logic       SCK,
  input  wire logic       CS_N,
  input  wire logic [3:0] IO_IN,
  input  wire logic       QUAD_MODE,
  input  wire logic       RESUME_SEL,
  input  wire logic       ADDR_WIDE,
  output logic            CMD_VALID,
  output logic [7:0]      OPCODE,
  output fdc_cmd_t        CMD_CODE,
  output logic [2:0]      ADDR_BYTES,
  output logic [7:0]      MAX_MHZ,
  output logic            QUAD_OK,
  output logic            CMD_LEGAL,
  output logic            FAIL_CLEAR,
  output logic            PE_RESUME,
  output logic            WIDE_ENTER
);

  // ---------------------------------------------------------------
  // link side: frame counter and flags, cleared by the frame itself
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] cnt;
    logic       quad_done;
    logic       ser_done;
  } fdc_lnk_t;

  typedef struct packed {
    logic [7:0] ser;
    logic [7:0] nib;
  } fdc_lnk_dat_t;

  fdc_lnk_t     lnk_ff, nxt_lnk;
  fdc_lnk_dat_t dat_ff, nxt_dat;

  // the serial clock stops between frames, so CS_N high clears the flags without it
  always_comb begin
    nxt_lnk = lnk_ff;
    nxt_dat = dat_ff;
    if (lnk_ff.cnt < BITS_SERIAL) begin
      nxt_lnk.cnt = lnk_ff.cnt + 4'h1;
      nxt_dat.ser = {dat_ff.ser[6:0], IO_IN[0]};
    end
    if (lnk_ff.cnt < BITS_QUAD) begin
      nxt_dat.nib = {dat_ff.nib[3:0], IO_IN};
    end
    if (lnk_ff.cnt == BITS_QUAD - 4'h1) begin
      nxt_lnk.quad_done = 1'b1;
    end
    if (lnk_ff.cnt == BITS_SERIAL - 4'h1) begin
      nxt_lnk.ser_done = 1'b1;
    end
  end

  always_ff @(posedge SCK or posedge CS_N) begin
    if (CS_N) begin
      lnk_ff <= '0;
    end else begin
      lnk_ff <= nxt_lnk;
    end
  end

  // shift data is held past the frame so the system side can read it after the flag crossing
  always_ff @(posedge SCK) begin
    dat_ff <= nxt_dat;
  end

  // ---------------------------------------------------------------
  // system side: flag synchronisers and decode
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] q_sync;
    logic [2:0] s_sync;
    logic       valid;
    logic [7:0] opcode;
    fdc_dec_t   dec;
    logic       legal;
    logic       fail_clear;
    logic       pe_resume;
    logic       wide_enter;
  } fdc_sys_t;

  fdc_sys_t sys_ff, nxt_sys;
  logic     evt;
  logic [7:0] op_in;
  fdc_dec_t dec_in;

  always_comb begin
    nxt_sys = sys_ff;
    nxt_sys.q_sync = {sys_ff.q_sync[1:0], lnk_ff.quad_done};
    nxt_sys.s_sync = {sys_ff.s_sync[1:0], lnk_ff.ser_done};
    // nibble path after two clocks in quad mode, serial path after eight otherwise
    evt = QUAD_MODE ? (sys_ff.q_sync[1] & ~sys_ff.q_sync[2])
                    : (sys_ff.s_sync[1] & ~sys_ff.s_sync[2]);
    op_in  = QUAD_MODE ? dat_ff.nib : dat_ff.ser;
    dec_in = fdc_decode(op_in, RESUME_SEL, ADDR_WIDE);
    nxt_sys.valid = evt;
    nxt_sys.fail_clear = 1'b0;
    nxt_sys.pe_resume = 1'b0;
    nxt_sys.wide_enter = 1'b0;
    if (evt) begin
      nxt_sys.opcode = op_in;
      nxt_sys.dec = dec_in;
      // quad-illegal commands are flagged, not acted on; their effect is undefined anyway
      nxt_sys.legal = dec_in.known & (~QUAD_MODE | dec_in.quad_ok);
      nxt_sys.fail_clear = nxt_sys.legal & (dec_in.cmd == CMD_FAIL_CLEAR);
      nxt_sys.pe_resume = nxt_sys.legal & (dec_in.cmd == CMD_PE_RESUME);
      nxt_sys.wide_enter = nxt_sys.legal & (dec_in.cmd == CMD_WIDE_ENTRY);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      sys_ff <= '{q_sync: 3'h0, s_sync: 3'h0, valid: 1'b0, opcode: 8'h00,
                  dec: '{cmd: CMD_NONE, addr_bytes: ADDR_NONE, max_mhz: 8'h00, quad_ok: 1'b0, known: 1'b0},
                  legal: 1'b0, fail_clear: 1'b0, pe_resume: 1'b0, wide_enter: 1'b0};
    end else begin
      sys_ff <= nxt_sys;
    end
  end

  assign CMD_VALID  = sys_ff.valid;
  assign OPCODE     = sys_ff.opcode;
  assign CMD_CODE   = sys_ff.dec.cmd;
  assign ADDR_BYTES = sys_ff.dec.addr_bytes;
  assign MAX_MHZ    = sys_ff.dec.max_mhz;
  assign QUAD_OK    = sys_ff.dec.quad_ok;
  assign CMD_LEGAL  = sys_ff.legal;
  assign FAIL_CLEAR = sys_ff.fail_clear;
  assign PE_RESUME  = sys_ff.pe_resume;
  assign WIDE_ENTER = sys_ff.wide_enter;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);

  chk_id_reads: assert property (CMD_VALID && (OPCODE == 8'h9F || OPCODE == 8'hAF)
    |-> ADDR_BYTES == 3'h0 && MAX_MHZ == 8'd133 && QUAD_OK && CMD_LEGAL) else $error("id read decode");
  chk_param_read: assert property (CMD_VALID && OPCODE == 8'h5A
    |-> CMD_CODE == CMD_PARAM_READ && ADDR_BYTES == 3'h3 && MAX_MHZ == 8'd50 && QUAD_OK) else $error("param read");
  chk_sr1_read: assert property (CMD_VALID && OPCODE == 8'h05
    |-> CMD_CODE == CMD_SR1_READ && ADDR_BYTES == 3'h0 && MAX_MHZ == 8'd133 && CMD_LEGAL) else $error("sr1");
  chk_no_quad: assert property (CMD_VALID && $past(QUAD_MODE) && (OPCODE == 8'h07 || OPCODE == 8'h35
    || OPCODE == 8'hB7 || OPCODE == 8'h41 || OPCODE == 8'h43 || OPCODE == 8'h4A)
    |-> !CMD_LEGAL && !WIDE_ENTER) else $error("quad illegal accepted");
  chk_sc_write: assert property (CMD_VALID && OPCODE == 8'h01
    |-> CMD_CODE == CMD_SC_WRITE && QUAD_OK && CMD_LEGAL) else $error("write reg");
  chk_clear_pick: assert property (CMD_VALID && OPCODE == 8'h30
    |-> (FAIL_CLEAR != PE_RESUME) && (PE_RESUME == $past(RESUME_SEL))) else $error("30 select");
  chk_alt_clear: assert property (CMD_VALID && OPCODE == 8'h82 |-> FAIL_CLEAR && !PE_RESUME)
    else $error("82 clear");
  chk_legacy_len: assert property (CMD_VALID && (OPCODE == 8'h65 || OPCODE == 8'h71)
    |-> ADDR_BYTES == ($past(ADDR_WIDE) ? 3'h4 : 3'h3)) else $error("legacy address length");
  chk_one_pulse: assert property (CMD_VALID |=> !CMD_VALID[*2]) else $error("valid not a pulse");
  chk_pulse_tie: assert property ((FAIL_CLEAR || PE_RESUME || WIDE_ENTER) |-> CMD_VALID && CMD_LEGAL)
    else $error("action without command");
  chk_serial_evt: assert property (!QUAD_MODE && $rose(sys_ff.s_sync[2]) && $past(!QUAD_MODE)
    |-> CMD_VALID) else $error("serial opcode missed");

  // ---------------------------------------------------------------
  // per-command decode checks
  // ---------------------------------------------------------------
  chk_id_codes: assert property (CMD_VALID && (OPCODE == 8'h9F || OPCODE == 8'hAF)
    |-> CMD_CODE == (OPCODE == 8'h9F ? CMD_ID_READ : CMD_QID_READ))
    else $error("id read code");
  chk_sr2_read: assert property (CMD_VALID && OPCODE == 8'h07
    |-> CMD_CODE == CMD_SR2_READ && ADDR_BYTES == 3'h0 && !QUAD_OK)
    else $error("status two decode");
  chk_cr1_read: assert property (CMD_VALID && OPCODE == 8'h35
    |-> CMD_CODE == CMD_CR1_READ && ADDR_BYTES == 3'h0 && !QUAD_OK)
    else $error("config one decode");
  chk_sc_noaddr: assert property (CMD_VALID && OPCODE == 8'h01
    |-> ADDR_BYTES == 3'h0 && MAX_MHZ == 8'h85)
    else $error("write reg fields");
  chk_fail_legal: assert property (CMD_VALID && OPCODE == 8'h30 && !$past(RESUME_SEL)
    |-> FAIL_CLEAR && CMD_CODE == CMD_FAIL_CLEAR && ADDR_BYTES == 3'h0)
    else $error("30 clear decode");
  chk_resume_code: assert property (CMD_VALID && OPCODE == 8'h30 && $past(RESUME_SEL)
    |-> PE_RESUME && CMD_CODE == CMD_PE_RESUME && !FAIL_CLEAR)
    else $error("30 resume decode");
  chk_alt_code: assert property (CMD_VALID && OPCODE == 8'h82
    |-> CMD_CODE == CMD_FAIL_CLEAR && CMD_LEGAL && ADDR_BYTES == 3'h0)
    else $error("82 decode");
  chk_wide_cmd: assert property (CMD_VALID && OPCODE == 8'hB7
    |-> CMD_CODE == CMD_WIDE_ENTRY && !QUAD_OK && WIDE_ENTER == CMD_LEGAL)
    else $error("wide entry decode");
  chk_lp_read: assert property (CMD_VALID && OPCODE == 8'h41
    |-> CMD_CODE == CMD_LP_READ && ADDR_BYTES == 3'h0 && MAX_MHZ == 8'h85 && !QUAD_OK)
    else $error("pattern read decode");
  chk_lp_nvprog: assert property (CMD_VALID && OPCODE == 8'h43
    |-> CMD_CODE == CMD_LP_NV_PROG && ADDR_BYTES == 3'h0 && !QUAD_OK)
    else $error("pattern program decode");
  chk_lp_volwr: assert property (CMD_VALID && OPCODE == 8'h4A
    |-> CMD_CODE == CMD_LP_VOL_WRITE && ADDR_BYTES == 3'h0 && !QUAD_OK)
    else $error("pattern write decode");
  chk_any_codes: assert property (CMD_VALID && (OPCODE == 8'h65 || OPCODE == 8'h71)
    |-> QUAD_OK && CMD_CODE == (OPCODE == 8'h65 ? CMD_ANY_READ : CMD_ANY_WRITE))
    else $error("any register decode");

  // ---------------------------------------------------------------
  // legality and action checks
  // ---------------------------------------------------------------
  chk_quad_legal: assert property (CMD_VALID && $past(QUAD_MODE) && QUAD_OK && CMD_CODE != CMD_NONE
    |-> CMD_LEGAL)
    else $error("quad command refused");
  chk_serial_legal: assert property (CMD_VALID && !$past(QUAD_MODE) && CMD_CODE != CMD_NONE
    |-> CMD_LEGAL)
    else $error("serial command refused");
  chk_unknown_op: assert property (CMD_VALID && CMD_CODE == CMD_NONE
    |-> !CMD_LEGAL && MAX_MHZ == 8'h00 && !FAIL_CLEAR && !PE_RESUME && !WIDE_ENTER)
    else $error("unknown opcode acted on");
  chk_wide_only: assert property (WIDE_ENTER |-> OPCODE == 8'hB7)
    else $error("wide entry from other opcode");
  chk_resume_only: assert property (PE_RESUME |-> OPCODE == 8'h30)
    else $error("resume from other opcode");
  chk_clear_only: assert property (FAIL_CLEAR |-> OPCODE == 8'h30 || OPCODE == 8'h82)
    else $error("clear from other opcode");
  chk_pulse_len: assert property ((FAIL_CLEAR || PE_RESUME || WIDE_ENTER)
    |=> !FAIL_CLEAR && !PE_RESUME && !WIDE_ENTER)
    else $error("action pulse too long");

  // ---------------------------------------------------------------
  // hold checks: decode fields stand until the next opcode
  // ---------------------------------------------------------------
  chk_hold_op: assert property (!CMD_VALID |-> $stable(OPCODE) && $stable(CMD_CODE))
    else $error("opcode changed without decode");
  chk_hold_fields: assert property (!CMD_VALID
    |-> $stable(ADDR_BYTES) && $stable(MAX_MHZ) && $stable(CMD_LEGAL) && $stable(QUAD_OK))
    else $error("fields changed without decode");

endmodule : fdc_decoder
`default_nettype wire

// ---- design/fdc_pkg.sv ----
// opcode table, decode result type and decode function for the command decoder
// assumes the opcode byte arrives already assembled; no bus, all controls are plain ports
`default_nettype none
package fdc_pkg;

  // ---------------------------------------------------------------
  // opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_ID_READ        = 8'h9F;
  localparam logic [7:0] OP_QID_READ       = 8'hAF;
  localparam logic [7:0] OP_PARAM_READ     = 8'h5A;
  localparam logic [7:0] OP_SR1_READ       = 8'h05;
  localparam logic [7:0] OP_SR2_READ       = 8'h07;
  localparam logic [7:0] OP_CR1_READ       = 8'h35;
  localparam logic [7:0] OP_SC_WRITE       = 8'h01;
  localparam logic [7:0] OP_FAIL_CLEAR     = 8'h30;
  localparam logic [7:0] OP_FAIL_CLEAR_ALT = 8'h82;
  localparam logic [7:0] OP_WIDE_ENTRY     = 8'hB7;
  localparam logic [7:0] OP_LP_READ        = 8'h41;
  localparam logic [7:0] OP_LP_NV_PROG     = 8'h43;
  localparam logic [7:0] OP_LP_VOL_WRITE   = 8'h4A;
  localparam logic [7:0] OP_ANY_READ       = 8'h65;
  localparam logic [7:0] OP_ANY_WRITE      = 8'h71;

  // ---------------------------------------------------------------
  // field values and counts
  // ---------------------------------------------------------------
  localparam logic [2:0] ADDR_NONE   = 3'h0;
  localparam logic [2:0] ADDR_SHORT  = 3'h3;
  localparam logic [2:0] ADDR_LONG   = 3'h4;
  localparam logic [7:0] MHZ_FAST    = 8'h85;  // 133
  localparam logic [7:0] MHZ_SLOW    = 8'h32;  // 50
  localparam logic [3:0] BITS_SERIAL = 4'h8;
  localparam logic [3:0] BITS_QUAD   = 4'h2;

  typedef enum logic [3:0] {
    CMD_NONE, CMD_ID_READ, CMD_QID_READ, CMD_PARAM_READ, CMD_SR1_READ, CMD_SR2_READ,
    CMD_CR1_READ, CMD_SC_WRITE, CMD_FAIL_CLEAR, CMD_PE_RESUME, CMD_WIDE_ENTRY,
    CMD_LP_READ, CMD_LP_NV_PROG, CMD_LP_VOL_WRITE, CMD_ANY_READ, CMD_ANY_WRITE
  } fdc_cmd_t;

  typedef struct packed {
    fdc_cmd_t   cmd;
    logic [2:0] addr_bytes;
    logic [7:0] max_mhz;
    logic       quad_ok;
    logic       known;
  } fdc_dec_t;

  function automatic fdc_dec_t fdc_decode(input logic [7:0] op, input logic resume_sel,
                                          input logic addr_wide);
    fdc_dec_t d;
    logic [2:0] legacy;
    d = '{cmd: CMD_NONE, addr_bytes: ADDR_NONE, max_mhz: MHZ_FAST, quad_ok: 1'b0, known: 1'b1};
    legacy = addr_wide ? ADDR_LONG : ADDR_SHORT;
    unique case (op)
      OP_ID_READ: begin
        d.cmd = CMD_ID_READ;
        d.quad_ok = 1'b1;
      end
      OP_QID_READ: begin
        d.cmd = CMD_QID_READ;
        d.quad_ok = 1'b1;
      end
      OP_PARAM_READ: begin
        d.cmd = CMD_PARAM_READ;
        d.addr_bytes = ADDR_SHORT;
        d.max_mhz = MHZ_SLOW;
        d.quad_ok = 1'b1;
      end
      OP_SR1_READ: begin
        d.cmd = CMD_SR1_READ;
        d.quad_ok = 1'b1;
      end
      OP_SR2_READ:     d.cmd = CMD_SR2_READ;
      OP_CR1_READ:     d.cmd = CMD_CR1_READ;
      OP_SC_WRITE: begin
        d.cmd = CMD_SC_WRITE;
        d.quad_ok = 1'b1;
      end
      OP_FAIL_CLEAR: begin
        d.cmd = resume_sel ? CMD_PE_RESUME : CMD_FAIL_CLEAR;
        d.quad_ok = 1'b1;
      end
      OP_FAIL_CLEAR_ALT: begin
        d.cmd = CMD_FAIL_CLEAR;
        d.quad_ok = 1'b1;
      end
      OP_WIDE_ENTRY:   d.cmd = CMD_WIDE_ENTRY;
      OP_LP_READ:      d.cmd = CMD_LP_READ;
      OP_LP_NV_PROG:   d.cmd = CMD_LP_NV_PROG;
      OP_LP_VOL_WRITE: d.cmd = CMD_LP_VOL_WRITE;
      OP_ANY_READ: begin
        d.cmd = CMD_ANY_READ;
        d.addr_bytes = legacy;
        d.quad_ok = 1'b1;
      end
      OP_ANY_WRITE: begin
        d.cmd = CMD_ANY_WRITE;
        d.addr_bytes = legacy;
        d.quad_ok = 1'b1;
      end
      default: begin
        d.known = 1'b0;
        d.max_mhz = 8'h00;
      end
    endcase
    return d;
  endfunction : fdc_decode

endpackage : fdc_pkg
`default_nettype wire

// ---- sim/fdc_decoder_test.sv ----
// self-checking bench for the command decoder
// assumes the host model in fdc_host_model drives the link side
`default_nettype none
module fdc_decoder_test;
  import fdc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] op;
    fdc_cmd_t   cmd;
    logic [2:0] ab;
    logic [7:0] mhz;
    logic       qok;
    logic       legal;
    logic       fc;
    logic       per;
    logic       we;
  } fdc_exp_t;
  logic       ref_clk, rstn, sck, cs_n, quad_mode, resume_sel, addr_wide;
  logic       cmd_valid, quad_ok, cmd_legal, fail_clear, pe_resume, wide_enter;
  logic [3:0] io;
  logic [7:0] opcode, max_mhz;
  logic [2:0] addr_bytes;
  fdc_cmd_t   cmd_code;
  fdc_exp_t   exp_q[$];
  fdc_exp_t   e;
  int         err_total = 0;
  int         samples_checked = 0;
  logic [31:0] seed = 32'h4E;
  // ---------------------------------------------------------------
  // clock, instances, expectation
  // ---------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  fdc_host_model host_u (.sck(sck), .cs_n(cs_n), .io(io));
  fdc_decoder dut_u (.REF_CLK(ref_clk), .RSTN(rstn), .SCK(sck), .CS_N(cs_n), .IO_IN(io),
    .QUAD_MODE(quad_mode), .RESUME_SEL(resume_sel), .ADDR_WIDE(addr_wide), .CMD_VALID(cmd_valid),
    .OPCODE(opcode), .CMD_CODE(cmd_code), .ADDR_BYTES(addr_bytes), .MAX_MHZ(max_mhz),
    .QUAD_OK(quad_ok), .CMD_LEGAL(cmd_legal), .FAIL_CLEAR(fail_clear), .PE_RESUME(pe_resume),
    .WIDE_ENTER(wide_enter));
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xorshift
  function automatic fdc_exp_t calc(input logic [7:0] op, input logic [2:0] c);
    fdc_exp_t x;
    x = '{op: op, cmd: CMD_NONE, ab: ADDR_NONE, mhz: MHZ_FAST, qok: 1'b0, legal: 1'b1, fc: 1'b0,
          per: 1'b0, we: 1'b0};
    case (op)
      OP_ID_READ:        x.cmd = CMD_ID_READ;
      OP_QID_READ:       x.cmd = CMD_QID_READ;
      OP_PARAM_READ:     {x.ab, x.mhz} = {ADDR_SHORT, MHZ_SLOW};
      OP_SR1_READ:       x.cmd = CMD_SR1_READ;
      OP_SR2_READ:       x.cmd = CMD_SR2_READ;
      OP_CR1_READ:       x.cmd = CMD_CR1_READ;
      OP_SC_WRITE:       x.cmd = CMD_SC_WRITE;
      OP_FAIL_CLEAR:     x.cmd = c[1] ? CMD_PE_RESUME : CMD_FAIL_CLEAR;
      OP_FAIL_CLEAR_ALT: x.cmd = CMD_FAIL_CLEAR;
      OP_WIDE_ENTRY:     x.cmd = CMD_WIDE_ENTRY;
      OP_LP_READ:        x.cmd = CMD_LP_READ;
      OP_LP_NV_PROG:     x.cmd = CMD_LP_NV_PROG;
      OP_LP_VOL_WRITE:   x.cmd = CMD_LP_VOL_WRITE;
      OP_ANY_READ:       x.cmd = CMD_ANY_READ;
      OP_ANY_WRITE:      x.cmd = CMD_ANY_WRITE;
      default:           {x.legal, x.mhz} = 9'h000;
    endcase
    if (op == OP_PARAM_READ) x.cmd = CMD_PARAM_READ;
    if (op == OP_ANY_READ || op == OP_ANY_WRITE) x.ab = c[0] ? ADDR_LONG : ADDR_SHORT;
    x.qok   = op inside {8'h9F, 8'hAF, 8'h5A, 8'h05, 8'h01, 8'h30, 8'h82, 8'h65, 8'h71};
    x.legal = x.legal & (~c[2] | x.qok);
    x.fc    = x.legal & (x.cmd == CMD_FAIL_CLEAR);
    x.per   = x.legal & (x.cmd == CMD_PE_RESUME);
    x.we    = x.legal & (x.cmd == CMD_WIDE_ENTRY);
    return x;
  endfunction : calc
  // ---------------------------------------------------------------
  // result watcher
  // ---------------------------------------------------------------
  always @(posedge ref_clk) begin
    #1;
    if (rstn === 1'b1 && cmd_valid !== 1'b1 && {fail_clear, pe_resume, wide_enter} !== 3'h0) begin
      err_total++;
      $display("MISMATCH t=%0t action pulse without decode", $time);
    end
    if (rstn === 1'b1 && cmd_valid === 1'b1) begin
      samples_checked++;
      if (exp_q.size() == 0) begin
        err_total++;
        $display("MISMATCH t=%0t unexpected decode of %h", $time, opcode);
      end else begin
        e = exp_q.pop_front();
        if ({opcode, cmd_code, addr_bytes, max_mhz, quad_ok, cmd_legal, fail_clear, pe_resume, wide_enter}
            !== e) begin
          err_total++;
          $display("MISMATCH t=%0t opcode %h decoded %h", $time, e.op, cmd_code);
        end
      end
    end
  end
  // ---------------------------------------------------------------
  // stimulus
  // ---------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  task automatic run(input logic [7:0] op, input logic [2:0] c, input int units);
    int t;
    @(negedge ref_clk);
    {quad_mode, resume_sel, addr_wide} = c;
    if (units == (c[2] ? 2 : 8)) exp_q.push_back(calc(op, c));
    host_u.frame(op, c[2], units);
    t = 0;
    while (exp_q.size() != 0 && t < 40) begin
      @(negedge ref_clk);
      t++;
    end
    if (exp_q.size() != 0) begin
      err_total++;
      $display("MISMATCH t=%0t no decode of %h", $time, op);
      print_verdict();
    end
  endtask : run
  initial begin
    automatic logic [7:0] ops[17] = '{8'h9F, 8'hAF, 8'h5A, 8'h05, 8'h07, 8'h35, 8'h01, 8'h30, 8'h82,
                                      8'hB7, 8'h41, 8'h43, 8'h4A, 8'h65, 8'h71, 8'h00, 8'hFF};
    {rstn, quad_mode, resume_sel, addr_wide} = 4'h0;
    repeat (3) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (3) @(negedge ref_clk);
    foreach (ops[i]) for (int k = 0; k < 8; k++) run(ops[i], k[2:0], k[2] ? 2 : 8);
    $display("known opcode sweep done");
    repeat (16) begin
      seed = xorshift(seed);
      run(seed[7:0], seed[10:8], seed[10] ? 2 : 8);
    end
    $display("random opcode test done");
    run(OP_ID_READ, 3'h0, 5);
    run(OP_SR1_READ, 3'h4, 1);
    repeat (20) @(negedge ref_clk);
    $display("short frame test done");
    print_verdict();
  end
endmodule : fdc_decoder_test
`default_nettype wire

// ---- sim/fdc_host_model.sv ----
// host spi controller model driving select, serial clock and lanes
// assumes mode 0: clock idles low between frames, device samples on rising edge
`default_nettype none
module fdc_host_model (
  output logic       sck,
  output logic       cs_n,
  output logic [3:0] io
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // frame driver
  // ---------------------------------------------------------------
  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
    io   = 4'hA;
  end
  // 64 ns period keeps every command, the 50 MHz one too, under its limit
  task automatic frame(input logic [7:0] op, input logic quad, input int units);
    #3;
    cs_n = 1'b0;
    for (int i = 0; i < units; i++) begin
      io = quad ? (i == 0 ? op[7:4] : op[3:0]) : {~io[3:1], op[7 - i]};
      #32 sck = 1'b1;
      #32 sck = 1'b0;
    end
    #32;
    cs_n = 1'b1;
    // released lanes must not keep the last value
    io = ~io;
    #64;
  endtask : frame
endmodule : fdc_host_model
`default_nettype wire
